// ==== design/cabe_exec_core.sv ====
// execution core: accumulator ops, branches, bit ops, control, jump/call
// assumes program memory returns data one cycle after address, data space
// reads combinationally, interrupt request from same-clock logic
`include "cabe_defines.svh"
// Notes on behaviour
// - add, and, compare, subtract use accumulator and a data byte or immediate
// - clear, decrement, increment address any of 256 data-space bytes
// - complement, rotate through carry, shift left act on accumulator only
// - branches go only when carry, zero or tested bit condition holds
// - short branch reach is -15 to +16 from the branch address
// - bit-test branch reach is -126 to +129 via 8-bit signed byte
// - bit set/clear touches one bit, picked by a 3-bit field
// - jump and call reach the whole space with a 12-bit target
// - stop acts as wait while the watchdog function is selected
// - bit-test branch copies the tested bit into carry
module cabe_exec_core import cabe_pkg::*; #(
  parameter int STACK_DEPTH = `CABE_STACK_DEPTH
) (
  input  wire logic        i_clk_sys,  // core clock, 200 MHz
  input  wire logic        i_rst_n,    // async reset, active low
  output logic [11:0]      o_pm_addr,  // program memory address
  input  wire logic [7:0]  i_pm_data,  // program byte, one cycle after address
  output logic [7:0]       o_ds_addr,  // data-space address
  input  wire logic [7:0]  i_ds_rdata, // data-space read byte
  output logic [7:0]       o_ds_wdata, // data-space write byte
  output logic             o_ds_we,    // data-space write strobe
  input  wire logic        i_wdog_sel, // watchdog function selected
  input  wire logic        i_irq_req,  // interrupt request level
  input  wire logic [11:0] i_irq_vec,  // interrupt vector
  output logic             o_irq_ack,  // interrupt taken pulse
  output logic [7:0]       o_acc,      // accumulator
  output logic             o_flag_z,   // zero flag
  output logic             o_flag_c,   // carry flag
  output logic             o_wait,     // core in wait mode
  output logic             o_stop,     // core in stop mode
  output logic             o_done,     // last cycle of an instruction
  output logic [11:0]      o_pc        // address of current instruction
);
  if (STACK_DEPTH < 2) begin : g_chk
    $error("cabe_exec_core: STACK_DEPTH must be at least 2");
  end

  ////////////////////////////////////////////////////////////////////////
  function automatic logic is_short(input logic [7:0] op);
    return ~op[0];
  endfunction : is_short
  function automatic logic [2:0] last_cyc(input logic [7:0] op);
    logic [2:0] n;
    n = `CABE_CYC_ALU;
    if (is_short(op) || op[3:0] == `CABE_CLS_CTRL) n = `CABE_CYC_SHORT;
    else if (op[3:0] == `CABE_CLS_BIT_TEST) n = `CABE_CYC_BIT_TEST;
    else if (op[3:0] == `CABE_CLS_CALL || op[3:0] == `CABE_CLS_JUMP) n = `CABE_CYC_JUMP;
    return n - 3'd1;
  endfunction : last_cyc
  // {update flags, write acc, z, c, result}
  function automatic logic [11:0] alu(input logic [3:0] fn, input logic [7:0] a,
                                      input logic [7:0] b, input logic c);
    logic [8:0] s;
    logic       upd;
    logic       wr;
    logic       cy;
    logic [7:0] r;
    s   = 9'h000;
    upd = 1'b1;
    wr  = 1'b1;
    cy  = c;
    r   = a;
    case (fn)
      `CABE_FN_ADD:        begin s = {1'b0, a} + {1'b0, b}; r = s[7:0]; cy = s[8]; end
      `CABE_FN_AND:        begin r = a & b; cy = 1'b0; end
      `CABE_FN_COMPARE:    begin r = a - b; cy = (a < b); wr = 1'b0; end
      `CABE_FN_SUB:        begin r = a - b; cy = (a < b); end
      `CABE_FN_COMPLEMENT: begin r = ~a; cy = a[7]; end
      `CABE_FN_ROTATE:     begin r = {a[6:0], c}; cy = a[7]; end
      `CABE_FN_SHIFT:      begin r = {a[6:0], 1'b0}; cy = a[7]; end
      `CABE_FN_CLEAR_ACC:  begin r = 8'h00; cy = 1'b0; end
      default:             begin upd = 1'b0; wr = 1'b0; end
    endcase
    return {upd, wr, (r == 8'h00), cy, r};
  endfunction : alu
  ////////////////////////////////////////////////////////////////////////
  cabe_pc_type    pc_ff;
  cabe_pc_type    pm_addr_ff;
  cabe_pc_type    nxt_pc;
  logic [2:0]     cyc_ff;
  logic [7:0]     op_ff;
  logic [7:0]     b2_ff;
  logic [7:0]     b3_ff;
  logic           tbit_ff;
  logic [7:0]     acc_ff;
  logic           z_ff;
  logic           c_ff;
  logic           sz_ff;
  logic           sc_ff;
  logic [7:0]     ds_addr_ff;
  logic [7:0]     ds_wdata_ff;
  logic           ds_we_ff;
  logic           irq_ack_ff;
  cabe_mode_type  mode_ff;
  logic [7:0]     op;
  logic [3:0]     cls;
  logic [3:0]     fn;
  logic           running;
  logic           fin;
  logic           take_irq;
  logic           br_go;
  logic [11:0]    alu_out;
  logic [7:0]     mem_rslt;
  logic           inherent;
  cabe_stack_if sif ();
  cabe_ret_stack #(.DEPTH(STACK_DEPTH)) cabe_ret_stack_i (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .sif       (sif)
  );
  assign op       = (cyc_ff == 3'd1) ? i_pm_data : op_ff;
  assign cls      = op[3:0];
  assign fn       = op[7:4];
  assign running  = (mode_ff == MODE_RUN);
  assign fin      = running && cyc_ff != 3'd0 && cyc_ff == last_cyc(op);
  assign take_irq = (cyc_ff == 3'd0) && i_irq_req && !irq_ack_ff;
  assign inherent = (cls == `CABE_CLS_ALU_DIR) && fn >= `CABE_FN_COMPLEMENT;
  // condition field in bits 2:1 of the short forms
  always_comb begin
    case (op[2:1])
      2'b00:   br_go = ~z_ff;
      2'b01:   br_go = ~c_ff;
      2'b10:   br_go = z_ff;
      default: br_go = c_ff;
    endcase
  end
  // immediate operand from the second byte, else the data-space byte
  assign alu_out = alu(fn, acc_ff, (cls == `CABE_CLS_ALU_IMM) ? b2_ff : i_ds_rdata,
                       c_ff);
  always_comb begin
    case (fn)
      `CABE_MEM_INC: mem_rslt = i_ds_rdata + 8'h01;
      `CABE_MEM_DEC: mem_rslt = i_ds_rdata - 8'h01;
      default:       mem_rslt = 8'h00;
    endcase
  end
  always_comb begin
    nxt_pc = pc_ff + 12'd1;
    if (is_short(op)) begin
      if (br_go) begin
        nxt_pc = op[3] ? pc_ff - {8'h00, op[7:4]}
                       : pc_ff + {8'h00, op[7:4]} + 12'd1;
      end
    end else begin
      case (cls)
        `CABE_CLS_CALL,
        `CABE_CLS_JUMP:     nxt_pc = {op[7:4], b2_ff};
        `CABE_CLS_BIT_TEST: nxt_pc = (tbit_ff == op[4])
                                     ? pc_ff + 12'd2 + {{4{b3_ff[7]}}, b3_ff}
                                     : pc_ff + 12'd3;
        `CABE_CLS_CTRL:     if (fn == `CABE_CTL_RET || fn == `CABE_CTL_RETURN_FROM_INTERRUPT) nxt_pc = sif.top;
        `CABE_CLS_ALU_DIR:  if (!inherent) nxt_pc = pc_ff + 12'd2;
        default:            nxt_pc = pc_ff + 12'd2;
      endcase
    end
  end
  assign sif.push      = take_irq || (fin && cls == `CABE_CLS_CALL);
  assign sif.push_data = take_irq ? pc_ff : pc_ff + 12'd2;
  // a return with nothing stacked leaves the stack alone
  assign sif.pop       = fin && !sif.empty && cls == `CABE_CLS_CTRL &&
                         (fn == `CABE_CTL_RET || fn == `CABE_CTL_RETURN_FROM_INTERRUPT);
  ////////////////////////////////////////////////////////////////////////
  // sequencing and fetch; cycle 0 issues the next byte address
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pc_ff      <= `CABE_RST_PC;
      pm_addr_ff <= `CABE_RST_PC;
      cyc_ff     <= 3'd0;
    end else if (take_irq) begin
      pc_ff      <= i_irq_vec;
      pm_addr_ff <= i_irq_vec;
    end else if (running) begin
      if (cyc_ff == 3'd0) begin
        pm_addr_ff <= pc_ff + 12'd1;
        cyc_ff     <= 3'd1;
      end else if (fin) begin
        pc_ff      <= nxt_pc;
        pm_addr_ff <= nxt_pc;
        cyc_ff     <= 3'd0;
      end else begin
        if (cyc_ff == 3'd1) pm_addr_ff <= pc_ff + 12'd2;
        cyc_ff <= cyc_ff + 3'd1;
      end
    end
  end
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      op_ff   <= `CABE_RST_BYTE;
      b2_ff   <= `CABE_RST_BYTE;
      b3_ff   <= `CABE_RST_BYTE;
      tbit_ff <= 1'b0;
    end else if (running) begin
      if (cyc_ff == 3'd1) op_ff <= i_pm_data;
      if (cyc_ff == 3'd2) b2_ff <= i_pm_data;
      if (cyc_ff == 3'd3) begin
        b3_ff   <= i_pm_data;
        tbit_ff <= i_ds_rdata[op_ff[7:5]];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // data space; write lands in the next instruction's cycle 0, which
  // never reads data space, so there is no read-after-write hazard
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ds_addr_ff  <= `CABE_RST_BYTE;
      ds_wdata_ff <= `CABE_RST_BYTE;
      ds_we_ff    <= 1'b0;
    end else begin
      ds_we_ff <= 1'b0;
      if (running && cyc_ff == 3'd2) ds_addr_ff <= i_pm_data;
      if (fin && cls == `CABE_CLS_MEM && fn <= `CABE_MEM_CLEAR) begin
        ds_wdata_ff <= mem_rslt;
        ds_we_ff    <= 1'b1;
      end
      if (fin && cls == `CABE_CLS_BIT_MOD) begin
        ds_wdata_ff <= op_ff[4] ? (i_ds_rdata | (8'h01 << op_ff[7:5]))
                                : (i_ds_rdata & ~(8'h01 << op_ff[7:5]));
        ds_we_ff    <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // accumulator and flags; absent cases keep flags as they are
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc_ff <= `CABE_RST_BYTE;
      z_ff   <= 1'b0;
      c_ff   <= 1'b0;
      sz_ff  <= 1'b0;
      sc_ff  <= 1'b0;
    end else if (take_irq) begin
      sz_ff <= z_ff;
      sc_ff <= c_ff;
    end else if (fin) begin
      case (cls)
        `CABE_CLS_ALU_DIR,
        `CABE_CLS_ALU_IMM: if (alu_out[11] && (cls == `CABE_CLS_ALU_DIR || fn < 4'h4)) begin
          if (alu_out[10]) acc_ff <= alu_out[7:0];
          z_ff <= alu_out[9];
          c_ff <= alu_out[8];
        end
        `CABE_CLS_MEM: if (fn == `CABE_MEM_INC || fn == `CABE_MEM_DEC) begin
          z_ff <= (mem_rslt == 8'h00);
        end
        `CABE_CLS_BIT_TEST: c_ff <= tbit_ff;
        `CABE_CLS_CTRL: if (fn == `CABE_CTL_RETURN_FROM_INTERRUPT) begin
          z_ff <= sz_ff;
          c_ff <= sc_ff;
        end
        default: ;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // low-power modes; only an interrupt or reset leaves them
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_ff    <= MODE_RUN;
      irq_ack_ff <= 1'b0;
    end else begin
      irq_ack_ff <= take_irq;
      if (take_irq) begin
        mode_ff <= MODE_RUN;
      end else if (fin && cls == `CABE_CLS_CTRL) begin
        case (fn)
          `CABE_CTL_STOP: mode_ff <= i_wdog_sel ? MODE_WAIT : MODE_STOP;
          `CABE_CTL_WAIT: mode_ff <= MODE_WAIT;
          default:        mode_ff <= mode_ff;
        endcase
      end
    end
  end
  assign o_pm_addr  = pm_addr_ff;
  assign o_ds_addr  = ds_addr_ff;
  assign o_ds_wdata = ds_wdata_ff;
  assign o_ds_we    = ds_we_ff;
  assign o_irq_ack  = irq_ack_ff;
  assign o_acc      = acc_ff;
  assign o_flag_z   = z_ff;
  assign o_flag_c   = c_ff;
  assign o_wait     = (mode_ff == MODE_WAIT);
  assign o_stop     = (mode_ff == MODE_STOP);
  assign o_done     = fin;
  assign o_pc       = pc_ff;
endmodule : cabe_exec_core

// ==== design/cabe_defines.svh ====
// constants for the execution core: opcode classes, functions, cycle counts
// assumes inclusion by bare name from the package and modules
`ifndef CABE_DEFINES_SVH
`define CABE_DEFINES_SVH

// opcode low nibble selects the class; even nibbles are short branches
`define CABE_CLS_CALL      4'h1
`define CABE_CLS_JUMP      4'h9
`define CABE_CLS_BIT_TEST  4'h3
`define CABE_CLS_BIT_MOD   4'hb
`define CABE_CLS_ALU_DIR   4'h7
`define CABE_CLS_ALU_IMM   4'hf
`define CABE_CLS_MEM       4'h5
`define CABE_CLS_CTRL      4'hd

// accumulator functions, opcode high nibble
`define CABE_FN_ADD        4'h0
`define CABE_FN_AND        4'h1
`define CABE_FN_COMPARE    4'h2
`define CABE_FN_SUB        4'h3
`define CABE_FN_COMPLEMENT 4'h4
`define CABE_FN_ROTATE     4'h5
`define CABE_FN_SHIFT      4'h6
`define CABE_FN_CLEAR_ACC  4'h7

// data-space functions
`define CABE_MEM_INC       4'h0
`define CABE_MEM_DEC       4'h1
`define CABE_MEM_CLEAR     4'h2

// control functions
`define CABE_CTL_NOP       4'h0
`define CABE_CTL_RET       4'h1
`define CABE_CTL_RETURN_FROM_INTERRUPT      4'h2
`define CABE_CTL_STOP      4'h3
`define CABE_CTL_WAIT      4'h4

// cycles per instruction
`define CABE_CYC_ALU       3'd4
`define CABE_CYC_SHORT     3'd2
`define CABE_CYC_BIT_TEST  3'd5
`define CABE_CYC_JUMP      3'd4

// reset values and sizes
`define CABE_RST_PC        12'h000
`define CABE_RST_BYTE      8'h00
`define CABE_STACK_DEPTH   6
`define CABE_PC_W          12
`endif

// ==== design/cabe_pkg.sv ====
// types shared by the execution core and its return stack
// assumes cabe_defines.svh on the include path
`include "cabe_defines.svh"
package cabe_pkg;
  typedef enum logic [2:0] {
    MODE_RUN  = 3'b001,
    MODE_WAIT = 3'b010,
    MODE_STOP = 3'b100
  } cabe_mode_type;
  typedef logic [`CABE_PC_W-1:0] cabe_pc_type;
endpackage : cabe_pkg

// ==== design/cabe_stack_if.sv ====
// carrier between the core and its return-address stack
// assumes both ends on i_clk_sys
interface cabe_stack_if;
  import cabe_pkg::*;
  logic        push;
  logic        pop;
  cabe_pc_type push_data;
  cabe_pc_type top;
  logic        empty;
  modport core  (output push, output pop, output push_data, input top, input empty);
  modport stack (input push, input pop, input push_data, output top, output empty);
endinterface : cabe_stack_if

// ==== design/cabe_ret_stack.sv ====
// return-address stack, top of stack held in a register
// assumes push and pop never in the same cycle
`include "cabe_defines.svh"
module cabe_ret_stack import cabe_pkg::*; #(
  parameter int DEPTH = `CABE_STACK_DEPTH
) (
  input  wire logic   i_clk_sys, // core clock
  input  wire logic   i_rst_n,   // async reset, active low
  cabe_stack_if.stack sif        // core side
);
  localparam int SPW = $clog2(DEPTH + 1);
  if (DEPTH < 2) begin : g_chk
    $error("cabe_ret_stack: DEPTH must be at least 2");
  end

  cabe_pc_type          mem [DEPTH];
  logic [SPW-1:0]       sp_ff;
  cabe_pc_type          top_ff;

  ////////////////////////////////////////////////////////////////////////
  // overflow drops the push: the oldest entries are the ones kept
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sp_ff  <= '0;
      top_ff <= `CABE_RST_PC;
    end else if (sif.push && sp_ff != SPW'(DEPTH)) begin
      sp_ff  <= sp_ff + SPW'(1);
      top_ff <= sif.push_data;
    end else if (sif.pop && sp_ff != '0) begin
      sp_ff  <= sp_ff - SPW'(1);
      top_ff <= (sp_ff >= SPW'(2)) ? mem[sp_ff - SPW'(2)] : `CABE_RST_PC;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (sif.push && sp_ff != SPW'(DEPTH)) begin
      mem[sp_ff] <= sif.push_data;
    end
  end

  assign sif.top   = top_ff;
  assign sif.empty = (sp_ff == '0);
endmodule : cabe_ret_stack

// ==== tb/cabe_mem_model.sv ====
// program memory and data space behind the execution core
// assumes the bench preloads pm and ds by hierarchy after time zero
module cabe_mem_model (
  input  wire logic        i_clk_sys,  // core clock
  input  wire logic [11:0] i_pm_addr,  // program address
  output logic [7:0]       o_pm_data,  // byte one cycle after address
  input  wire logic [7:0]  i_ds_addr,  // data-space address
  output logic [7:0]       o_ds_rdata, // read byte, same cycle
  input  wire logic [7:0]  i_ds_wdata, // write byte
  input  wire logic        i_ds_we     // write strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] pm [4096];
  logic [7:0] ds [256];
  // unloaded program space reads as no-op so a stray fetch is harmless
  initial begin
    for (int k = 0; k < 4096; k++) pm[k] = 8'h0d;
    for (int k = 0; k < 256; k++) ds[k] = 8'h00;
  end
  always_ff @(posedge i_clk_sys) o_pm_data <= pm[i_pm_addr];
  assign o_ds_rdata = ds[i_ds_addr];
  always @(posedge i_clk_sys) if (i_ds_we) ds[i_ds_addr] <= i_ds_wdata;
endmodule : cabe_mem_model

// ==== tb/cabe_exec_core_chk.sv ====
// timing, flow and flag checks on the execution core's ports
// assumes an interrupt is taken only after a long sleep, so cycle counting follows o_done
module cabe_exec_core_chk (
  input wire logic        i_clk_sys,  // core clock
  input wire logic        i_rst_n,    // async reset, active low
  input wire logic [7:0]  i_pm_data,  // program byte
  input wire logic [7:0]  i_ds_rdata, // data-space read byte
  input wire logic        i_wdog_sel, // watchdog selected
  input wire logic [7:0]  o_ds_wdata, // write byte
  input wire logic        o_ds_we,    // write strobe
  input wire logic        o_flag_z,   // zero flag
  input wire logic        o_flag_c,   // carry flag
  input wire logic        o_wait,     // wait mode
  input wire logic        o_stop,     // stop mode
  input wire logic        o_done,     // last instruction cycle
  input wire logic [11:0] o_pc        // current instruction
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  logic [2:0]  cnt_ff;
  logic [7:0]  op_ff;
  logic [7:0]  b2_ff;
  logic        run1;
  logic        brk;
  logic        idle;
  logic [11:0] sb_tgt;
  logic [7:0]  bm;
  // saturates so a sleeping core never looks like cycle 1
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) cnt_ff <= 3'd0;
    else if (o_done) cnt_ff <= 3'd0;
    else if (cnt_ff != 3'd7) cnt_ff <= cnt_ff + 3'd1;
  end
  always_ff @(posedge i_clk_sys) begin
    if (cnt_ff == 3'd1) op_ff <= i_pm_data;
    if (cnt_ff == 3'd2) b2_ff <= i_pm_data;
  end
  always_comb begin
    idle = o_wait || o_stop;
    run1 = cnt_ff == 3'd1 && !idle;
    case (i_pm_data[2:1])
      2'b00:   brk = !o_flag_z;
      2'b01:   brk = !o_flag_c;
      2'b10:   brk = o_flag_z;
      default: brk = o_flag_c;
    endcase
    sb_tgt = o_pc + 12'h001;
    if (brk && i_pm_data[3]) sb_tgt = o_pc - {8'h00, i_pm_data[7:4]};
    if (brk && !i_pm_data[3]) sb_tgt = o_pc + {8'h00, i_pm_data[7:4]} + 12'h001;
    bm = i_ds_rdata & ~(8'h01 << op_ff[7:5]);
    if (op_ff[4]) bm = i_ds_rdata | (8'h01 << op_ff[7:5]);
  end
  short_len_a: assert property ((run1 && (!i_pm_data[0] || i_pm_data[3:0] == 4'hd)) |-> o_done)
    else $error("short instruction not done in cycle 1");
  alu_len_a: assert property ((run1 && i_pm_data[2:0] == 3'b111) |=> !o_done ##1 o_done)
    else $error("accumulator op not four cycles");
  test_len_a: assert property ((run1 && i_pm_data[3:0] == 4'h3) |=> !o_done [*2] ##1 o_done)
    else $error("bit test not five cycles");
  short_flags_a: assert property ((run1 && !i_pm_data[0]) |=> $stable({o_flag_z, o_flag_c}))
    else $error("short branch changed flags");
  short_target_a: assert property ((run1 && !i_pm_data[0]) |=> o_pc == $past(sb_tgt))
    else $error("short branch target wrong");
  far_target_a: assert property ((cnt_ff == 3'd3 && op_ff[2:0] == 3'b001 && !idle)
    |=> o_pc == {op_ff[7:4], b2_ff}) else $error("jump or call target wrong");
  bit_write_a: assert property ((cnt_ff == 3'd3 && op_ff[3:0] == 4'hb && !idle)
    |=> o_ds_we && o_ds_wdata == $past(bm)) else $error("bit modify write wrong");
  test_carry_a: assert property ((cnt_ff == 3'd4 && op_ff[3:0] == 4'h3 && !idle)
    |=> o_flag_c == $past(i_ds_rdata[op_ff[7:5]])) else $error("tested bit not in carry");
  stop_mode_a: assert property ((run1 && i_pm_data == 8'h3d)
    |=> o_wait == $past(i_wdog_sel) && o_stop == !$past(i_wdog_sel))
    else $error("stop mode wrong for watchdog");
endmodule : cabe_exec_core_chk

bind cabe_exec_core cabe_exec_core_chk cabe_exec_core_chk_i (
  .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_pm_data(i_pm_data), .i_ds_rdata(i_ds_rdata),
  .i_wdog_sel(i_wdog_sel), .o_ds_wdata(o_ds_wdata), .o_ds_we(o_ds_we), .o_flag_z(o_flag_z),
  .o_flag_c(o_flag_c), .o_wait(o_wait), .o_stop(o_stop), .o_done(o_done), .o_pc(o_pc));

// ==== tb/cabe_exec_core_test.sv ====
// self-checking bench: one program walks all instruction groups
// assumes one interrupt, taken from wait; program kept off port registers
module cabe_exec_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        wdog = 1'b0;
  logic [11:0] pm_addr, pc;
  logic [7:0]  pm_data, ds_addr, ds_rdata, ds_wdata, acc;
  logic        ds_we, fz, fc, wt, st, done;
  logic        irq = 1'b0;
  logic        ack;
  int          err_total = 0;
  int          cmp_count = 0;
  always #2.5 clk = ~clk;
  cabe_exec_core cabe_exec_core_i (.i_clk_sys(clk), .i_rst_n(rst_n), .o_pm_addr(pm_addr),
    .i_pm_data(pm_data), .o_ds_addr(ds_addr), .i_ds_rdata(ds_rdata), .o_ds_wdata(ds_wdata),
    .o_ds_we(ds_we), .i_wdog_sel(wdog), .i_irq_req(irq), .i_irq_vec(12'h700), .o_irq_ack(ack),
    .o_acc(acc), .o_flag_z(fz), .o_flag_c(fc), .o_wait(wt), .o_stop(st), .o_done(done),
    .o_pc(pc));
  cabe_mem_model cabe_mem_model_i (.i_clk_sys(clk), .i_pm_addr(pm_addr), .o_pm_data(pm_data),
    .i_ds_addr(ds_addr), .o_ds_rdata(ds_rdata), .i_ds_wdata(ds_wdata), .i_ds_we(ds_we));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [11:0] seen, input logic [11:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic end_sim();
    if (err_total == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  task automatic load(input logic [11:0] a, input logic [7:0] b [$]);
    foreach (b[k]) cabe_mem_model_i.pm[a + k] = b[k];
  endtask : load
  task automatic do_reset();
    @(negedge clk);
    rst_n = 1'b0;
    repeat (4) @(negedge clk);
    chk("rst_pc", pc, 12'h000);
    chk("rst_acc_flags", {2'b00, acc, fz, fc}, 12'h000);
    chk("rst_modes", {9'h000, ds_we, wt, st}, 12'h000);
    rst_n = 1'b1;
  endtask : do_reset
  // bounded wait; returns in the next instruction's cycle 0
  task automatic wait_done();
    int n;
    n = 0;
    while (done !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 12) begin
        chk("done_timeout", 12'h001, 12'h000);
        end_sim();
      end
    end
    @(negedge clk);
  endtask : wait_done
  task automatic step(input logic [11:0] npc, input logic [7:0] a, input logic [1:0] zc);
    wait_done();
    chk("next_pc", pc, npc);
    chk("acc", {4'h0, acc}, {4'h0, a});
    chk("flags", {10'h000, fz, fc}, {10'h000, zc});
  endtask : step
  //////////////////////////////////////////////////////////////////////////////
  task automatic acc_ops();
    step(12'h002, 8'h3c, 2'b00);
    step(12'h004, 8'h2c, 2'b01);
    step(12'h006, 8'h00, 2'b10);
    step(12'h008, 8'h00, 2'b01);
    step(12'h00a, 8'h00, 2'b10);
    step(12'h00b, 8'hff, 2'b00);
    step(12'h00c, 8'hfe, 2'b01);
    step(12'h00d, 8'hfd, 2'b01);
  endtask : acc_ops
  task automatic data_ops();
    step(12'h00f, 8'hfd, 2'b11);
    step(12'h011, 8'hfd, 2'b01);
    step(12'h013, 8'hfd, 2'b01);
  endtask : data_ops
  task automatic bit_ops();
    step(12'h015, 8'hfd, 2'b01);
    step(12'h017, 8'hfd, 2'b01);
    step(12'h098, 8'hfd, 2'b01);
    step(12'h01a, 8'hfd, 2'b00);
    step(12'h01d, 8'hfd, 2'b00);
    chk("ds_ff", {4'h0, cabe_mem_model_i.ds[8'hff]}, 12'h000);
    chk("ds_00", {4'h0, cabe_mem_model_i.ds[8'h00]}, 12'h0ff);
    chk("ds_80", {4'h0, cabe_mem_model_i.ds[8'h80]}, 12'h000);
    chk("ds_20", {4'h0, cabe_mem_model_i.ds[8'h20]}, 12'h080);
    chk("ds_21", {4'h0, cabe_mem_model_i.ds[8'h21]}, 12'h0fe);
  endtask : bit_ops
  task automatic flow_ops();
    step(12'h534, 8'hfd, 2'b00);
    step(12'he23, 8'hfd, 2'b00);
    step(12'h536, 8'hfd, 2'b00);
    step(12'h546, 8'hfd, 2'b00);
    step(12'h547, 8'hfd, 2'b00);
    step(12'h548, 8'hfd, 2'b00);
    step(12'h539, 8'hfd, 2'b00);
    step(12'h53a, 8'hfd, 2'b00);
  endtask : flow_ops
  // sleep long enough that the checker's cycle count saturates first
  task automatic irq_ops();
    repeat (8) @(negedge clk);
    irq = 1'b1;
    @(negedge clk);
    chk("irq_taken", {10'h000, ack, wt}, 12'h002);
    irq = 1'b0;
    step(12'h702, 8'h00, 2'b10);
    step(12'h53b, 8'h00, 2'b00);
  endtask : irq_ops
  task automatic stop_ops();
    wdog = 1'b1;
    wait_done();
    chk("wdog_modes", {10'h000, wt, st}, 12'h002);
    irq_ops();
    load(12'h000, {8'h3d});
    do_reset();
    wdog = 1'b0;
    wait_done();
    chk("stop_modes", {10'h000, wt, st}, 12'h001);
  endtask : stop_ops
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #1;
    load(12'h000, {8'h0f, 8'h3c, 8'h07, 8'h10, 8'h3f, 8'h2c, 8'h2f, 8'h01, 8'h1f, 8'hff,
                   8'h47, 8'h67, 8'h57, 8'h05, 8'hff, 8'h15, 8'h00, 8'h25, 8'h80, 8'hfb,
                   8'h20, 8'h0b, 8'h21, 8'hf3, 8'h20, 8'h7f});
    load(12'h098, {8'h03, 8'h21, 8'h80});
    load(12'h01a, {8'h13, 8'h21, 8'h00, 8'h59, 8'h34});
    load(12'h534, {8'he1, 8'h23, 8'hf0, 8'h0d, 8'h3d, 8'h0d, 8'h3d});
    load(12'h700, {8'h1f, 8'h00, 8'h2d});
    load(12'he23, {8'h1d});
    load(12'h546, {8'hfe, 8'h14, 8'hfa});
    cabe_mem_model_i.ds[8'h10] = 8'hf0;
    cabe_mem_model_i.ds[8'hff] = 8'hff;
    cabe_mem_model_i.ds[8'h80] = 8'h5a;
    cabe_mem_model_i.ds[8'h21] = 8'hff;
    do_reset();
    acc_ops();
    data_ops();
    bit_ops();
    flow_ops();
    stop_ops();
    end_sim();
  end
endmodule : cabe_exec_core_test
